// *** tmrwd_timer_subsystem.sv ***
// Purpose: Timer/counter with shared prescaler, option register and watchdog reset.
// Assumes: Core reset and clear instruction come from logic on the same clock.
// Notes: The event counter keeps its value across every reset.
//
// Notes on behaviour
// - Option low six preset, bit six separate.
// - Watchdog runs only while enable bit set.
// - Fifteen-bit up counter restarts after reset/clear.
// - Watchdog advances every sixteenth clock.
// - Core reset or clear instruction clears watchdog.
// - Terminal count with enable raises trip.
// - Prescaler on timer: trip resets core directly.
// - Prescaler on watchdog: reset after counted trips.
// - Prescaler divides clock/4 or external pin.
// - Each prescaler output adds exactly one.
// - Software loads counter; reset leaves it.
// - Count source captured by flop first.
// - One pulse after each synced falling edge.
// - Edge machine self-starts; test forces state.
// - Watchdog reset output held at least two cycles.
`timescale 1ns/100ps
`default_nettype none
module tmrwd_timer_subsystem (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_core_reset,
    input wire logic i_watchdog_clear_instr,
    input wire logic i_external_count_input,
    input wire logic i_test,
    input wire logic [tmrwd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [tmrwd_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [tmrwd_pkg::DATA_W-1:0] o_rdata,
    output logic o_watchdog_reset_out,
    output logic o_irq
);
    localparam logic [1:0] SRC_DIV_LAST = 2'(tmrwd_pkg::TMR_SRC_DIV - 1);
    localparam logic [1:0] HOLD_LAST = 2'(tmrwd_pkg::WRST_HOLD_CYCLES - 1);

    // Register port decode.
    logic wr_option;
    logic wr_timer;
    logic wr_status;
    logic wr_mask;

    assign wr_option = i_wr && (i_addr == tmrwd_pkg::ADDR_OPTION);
    assign wr_timer = i_wr && (i_addr == tmrwd_pkg::ADDR_TIMER);
    assign wr_status = i_wr && (i_addr == tmrwd_pkg::ADDR_STATUS);
    assign wr_mask = i_wr && (i_addr == tmrwd_pkg::ADDR_MASK);

    // Option register: six preset bits and a separate enable bit.
    logic [5:0] opt_low_reg;
    logic opt_wden_reg;
    tmrwd_pkg::tmrwd_opt_t opt;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_core_reset) begin
            opt_low_reg <= tmrwd_pkg::OPT_LOW_PRESET;
        end else if (wr_option) begin
            opt_low_reg <= i_wdata[5:0];
        end
    end

    // The enable bit has no preset of its own; only the system reset defines it.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            opt_wden_reg <= tmrwd_pkg::OPT_WDEN_RESET;
        end else if (wr_option) begin
            opt_wden_reg <= i_wdata[tmrwd_pkg::OPT_WDEN_BIT];
        end
    end

    always_comb begin
        opt.wd_en = opt_wden_reg;
        opt.src_ext = opt_low_reg[tmrwd_pkg::OPT_SRC_BIT];
        opt.src_invert = opt_low_reg[tmrwd_pkg::OPT_INVERT_BIT];
        opt.pre_to_wdog = opt_low_reg[tmrwd_pkg::OPT_ASSIGN_BIT];
        opt.ratio = opt_low_reg[tmrwd_pkg::OPT_RATIO_LSB +: 3];
    end

    // External pin passes two flip-flops before the source mux.
    logic ext_meta_reg;
    logic ext_sync_reg;

    always_ff @(posedge i_clk) begin
        ext_meta_reg <= i_external_count_input;
        ext_sync_reg <= ext_meta_reg;
    end

    // Quarter-rate source; only the system reset restarts it, so core resets keep its phase.
    logic [1:0] src_div_reg;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || src_div_reg == SRC_DIV_LAST) begin
            src_div_reg <= 2'h0;
        end else begin
            src_div_reg <= src_div_reg + 2'h1;
        end
    end

    logic count_source_raw;
    logic count_increment_pulse;

    assign count_source_raw = (opt.src_ext ? ext_sync_reg : src_div_reg[1]) ^ opt.src_invert;

    tmrwd_edge_det u_edge (
        .i_clk(i_clk),
        .i_test(i_test),
        .i_src_raw(count_source_raw),
        .o_inc(count_increment_pulse)
    );

    // Watchdog counter.
    logic wdog_clear;
    logic watchdog_trip;
    logic [tmrwd_pkg::WDOG_W-1:0] wdog_count;

    assign wdog_clear = i_core_reset || i_watchdog_clear_instr;

    tmrwd_watchdog u_wdog (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(wdog_clear),
        .i_enable(opt.wd_en),
        .o_trip(watchdog_trip),
        .o_count(wdog_count)
    );

    // Shared prescaler: counts timer source pulses or watchdog trips.
    logic [tmrwd_pkg::PRE_W-1:0] pre_reg;
    logic [tmrwd_pkg::PRE_W-1:0] pre_last;
    logic pre_event;
    logic pre_hit;
    logic pre_clear;

    assign pre_last = tmrwd_pkg::pre_limit(opt.ratio, opt.pre_to_wdog);
    assign pre_event = opt.pre_to_wdog ? watchdog_trip : count_increment_pulse;
    assign pre_hit = pre_event && (pre_reg == pre_last);
    // Reassigning, or reloading the timer while the prescaler serves it, restarts the division from zero.
    assign pre_clear = i_sys_rst || i_core_reset || wr_option
                       || (wr_timer && !opt.pre_to_wdog)
                       || (i_watchdog_clear_instr && opt.pre_to_wdog);

    always_ff @(posedge i_clk) begin
        if (pre_clear) begin
            pre_reg <= '0;
        end else if (pre_hit) begin
            pre_reg <= '0;
        end else if (pre_event) begin
            pre_reg <= pre_reg + 8'h01;
        end
    end

    // Event counter: no reset, software load wins over an increment.
    logic timer_inc;
    logic [tmrwd_pkg::DATA_W-1:0] timer_reg;
    logic timer_ovf;

    assign timer_inc = opt.pre_to_wdog ? count_increment_pulse : pre_hit;
    assign timer_ovf = timer_inc && !wr_timer && (timer_reg == 8'hFF);

    always_ff @(posedge i_clk) begin
        if (wr_timer) begin
            timer_reg <= i_wdata;
        end else if (timer_inc) begin
            timer_reg <= timer_reg + 8'h01;
        end
    end

    // Watchdog reset request and stretch.
    logic wdog_fire;
    logic [1:0] hold_reg;
    logic wrst_reg;

    assign wdog_fire = opt.pre_to_wdog ? pre_hit : watchdog_trip;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            hold_reg <= 2'h0;
            wrst_reg <= 1'b0;
        end else if (wdog_fire) begin
            hold_reg <= HOLD_LAST;
            wrst_reg <= 1'b1;
        end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end else begin
            wrst_reg <= 1'b0;
        end
    end

    assign o_watchdog_reset_out = wrst_reg;

    // Sticky status, write one to clear; a new event in the same cycle wins.
    logic [tmrwd_pkg::EVT_W-1:0] evt;
    logic [tmrwd_pkg::EVT_W-1:0] status_reg;
    logic [tmrwd_pkg::EVT_W-1:0] mask_reg;

    always_comb begin
        evt = '0;
        evt[tmrwd_pkg::EVT_TMR_OVF] = timer_ovf;
        evt[tmrwd_pkg::EVT_WDOG_TRIP] = watchdog_trip;
        evt[tmrwd_pkg::EVT_WDOG_RST] = wdog_fire;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            status_reg <= tmrwd_pkg::EVT_RESET;
        end else begin
            status_reg <= (status_reg & ~(wr_status ? i_wdata[tmrwd_pkg::EVT_W-1:0] : 3'h0))
                          | evt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mask_reg <= tmrwd_pkg::EVT_RESET;
        end else if (wr_mask) begin
            mask_reg <= i_wdata[tmrwd_pkg::EVT_W-1:0];
        end
    end

    logic irq_reg;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    assign o_irq = irq_reg;

    // Read port: data stand in the cycle after the strobe only.
    logic [tmrwd_pkg::DATA_W-1:0] rdata_next;
    logic [tmrwd_pkg::DATA_W-1:0] rdata_reg;

    always_comb begin
        case (i_addr)
            tmrwd_pkg::ADDR_OPTION: begin
                rdata_next = {1'b0, opt_wden_reg, opt_low_reg};
            end
            tmrwd_pkg::ADDR_TIMER: begin
                rdata_next = timer_reg;
            end
            tmrwd_pkg::ADDR_STATUS: begin
                rdata_next = {5'h00, status_reg};
            end
            tmrwd_pkg::ADDR_MASK: begin
                rdata_next = {5'h00, mask_reg};
            end
            tmrwd_pkg::ADDR_WDOG_LO: begin
                rdata_next = wdog_count[7:0];
            end
            tmrwd_pkg::ADDR_WDOG_HI: begin
                rdata_next = {1'b0, wdog_count[14:8]};
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !i_rd) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
endmodule
`default_nettype wire

// *** tmrwd_pkg.sv ***
// Purpose: Shared constants, types and decoding for the timer and watchdog block.
// Assumes: One 125 MHz clock; an 8-bit register port with reads answered one cycle later.
// Notes: Offsets, field positions, reset values and divide counts live here only.
package tmrwd_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int WDOG_W = 15;
    localparam int PRE_W = 8;

    // Register offsets.
    localparam logic [2:0] ADDR_OPTION = 3'h0;
    localparam logic [2:0] ADDR_TIMER = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_MASK = 3'h3;
    localparam logic [2:0] ADDR_WDOG_LO = 3'h4;
    localparam logic [2:0] ADDR_WDOG_HI = 3'h5;

    // Option register fields.
    localparam int OPT_RATIO_LSB = 0;
    localparam int OPT_ASSIGN_BIT = 3;
    localparam int OPT_INVERT_BIT = 4;
    localparam int OPT_SRC_BIT = 5;
    localparam int OPT_WDEN_BIT = 6;
    localparam logic [5:0] OPT_LOW_PRESET = 6'h3F;
    localparam logic OPT_WDEN_RESET = 1'b0;

    // Status and mask fields.
    localparam int EVT_W = 3;
    localparam int EVT_TMR_OVF = 0;
    localparam int EVT_WDOG_TRIP = 1;
    localparam int EVT_WDOG_RST = 2;
    localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

    // Timing counts in master clock cycles; the watchdog terminal count is in watchdog ticks.
    localparam int TMR_SRC_DIV = 4;
    localparam int WDOG_TICK_DIV = 16;
    localparam int WRST_HOLD_CYCLES = 2;
    localparam logic [WDOG_W-1:0] WDOG_TERMINAL = 15'h7FFF;

    typedef struct packed {
        logic wd_en;
        logic src_ext;
        logic src_invert;
        logic pre_to_wdog;
        logic [2:0] ratio;
    } tmrwd_opt_t;

    typedef enum logic [2:0] {
        EDGE_WAIT_HIGH = 3'b001,
        EDGE_WAIT_LOW = 3'b010,
        EDGE_PULSE = 3'b100
    } tmrwd_edge_state_t;

    // Last prescaler count before it emits: timer divides by 2^(r+1), watchdog by 2^r.
    function automatic logic [PRE_W-1:0] pre_limit(input logic [2:0] ratio, input logic to_wdog);
        logic [PRE_W:0] span;
        span = 9'h001 << (to_wdog ? {1'b0, ratio} : ({1'b0, ratio} + 4'h1));
        pre_limit = span[PRE_W-1:0] - 8'h01;
    endfunction

endpackage

// *** tmrwd_edge_det.sv ***
// Purpose: Capture the count source and give one pulse per falling edge.
// Assumes: The source may be asynchronous to the clock.
// Notes: The state machine has no reset and starts itself from any state.
`timescale 1ns/100ps
`default_nettype none
module tmrwd_edge_det (
    input wire logic i_clk,
    input wire logic i_test,
    input wire logic i_src_raw,
    output logic o_inc
);
    logic src_synced_reg;
    tmrwd_pkg::tmrwd_edge_state_t state_reg;
    tmrwd_pkg::tmrwd_edge_state_t state_next;

    always_ff @(posedge i_clk) begin
        src_synced_reg <= i_src_raw;
    end

    always_comb begin
        case (state_reg)
            tmrwd_pkg::EDGE_WAIT_HIGH: begin
                state_next = src_synced_reg ? tmrwd_pkg::EDGE_WAIT_LOW : tmrwd_pkg::EDGE_WAIT_HIGH;
            end
            tmrwd_pkg::EDGE_WAIT_LOW: begin
                state_next = src_synced_reg ? tmrwd_pkg::EDGE_WAIT_LOW : tmrwd_pkg::EDGE_PULSE;
            end
            tmrwd_pkg::EDGE_PULSE: begin
                state_next = src_synced_reg ? tmrwd_pkg::EDGE_WAIT_LOW : tmrwd_pkg::EDGE_WAIT_HIGH;
            end
            default: begin
                // Unknown or illegal codes fall back here, so no reset is needed.
                state_next = tmrwd_pkg::EDGE_WAIT_HIGH;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_test) begin
            state_reg <= tmrwd_pkg::EDGE_WAIT_HIGH;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_inc = (state_reg == tmrwd_pkg::EDGE_PULSE);
endmodule
`default_nettype wire

// *** tmrwd_watchdog.sv ***
// Purpose: Fifteen-bit watchdog counter advanced at one sixteenth of the clock.
// Assumes: The clear input is a level from the core reset or the clear instruction.
// Notes: The trip pulse is masked in the clear cycle, so a clear acts at once.
`timescale 1ns/100ps
`default_nettype none
module tmrwd_watchdog (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clear,
    input wire logic i_enable,
    output logic o_trip,
    output logic [tmrwd_pkg::WDOG_W-1:0] o_count
);
    localparam logic [3:0] TICK_LAST = 4'(tmrwd_pkg::WDOG_TICK_DIV - 1);
    logic [3:0] div_reg;
    logic [tmrwd_pkg::WDOG_W-1:0] count_reg;
    logic trip_reg;
    logic tick;

    assign tick = (div_reg == TICK_LAST);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_clear || !i_enable) begin
            count_reg <= '0;
        end else if (tick) begin
            count_reg <= count_reg + 15'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_clear) begin
            trip_reg <= 1'b0;
        end else begin
            trip_reg <= i_enable && tick && (count_reg == tmrwd_pkg::WDOG_TERMINAL);
        end
    end

    assign o_trip = trip_reg && !i_clear;
    assign o_count = count_reg;
endmodule
`default_nettype wire

// *** tmrwd_timer_subsystem_sva.sv ***
// Purpose: Port-level checks of the timer and watchdog block.
// Assumes: One clock; i_sys_rst is synchronous and active high.
// Notes: A full watchdog timeout is far longer than a short run, so trip checks may stay idle.
`timescale 1ns/100ps
`default_nettype none
module tmrwd_timer_subsystem_sva (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_core_reset,
    input wire logic i_watchdog_clear_instr,
    input wire logic [tmrwd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [tmrwd_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [tmrwd_pkg::DATA_W-1:0] o_rdata,
    input wire logic o_watchdog_reset_out,
    input wire logic o_irq
);
    logic en_q;
    logic [3:0] off_cnt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // The enable bit is shadowed from bus writes, since only sys reset clears it.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            en_q <= 1'b0;
        end else if (i_wr && i_addr == tmrwd_pkg::ADDR_OPTION) begin
            en_q <= i_wdata[tmrwd_pkg::OPT_WDEN_BIT];
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || en_q) begin
            off_cnt <= 4'h0;
        end else if (off_cnt != 4'h8) begin
            off_cnt <= off_cnt + 4'h1;
        end
    end
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    AST_RESET_OUT: assert property (disable iff (1'b0) i_sys_rst |=>
        (o_rdata == 8'h00 && !o_irq && !o_watchdog_reset_out)) else $error("bad reset outputs");
    AST_OPT_READBACK: assert property (i_wr && i_addr == tmrwd_pkg::ADDR_OPTION ##1 i_rd &&
        i_addr == tmrwd_pkg::ADDR_OPTION |=> o_rdata == (8'h7F & $past(i_wdata, 2)))
        else $error("option readback wrong");
    AST_TIMER_LOAD: assert property (i_wr && i_addr == tmrwd_pkg::ADDR_TIMER ##1 i_rd &&
        i_addr == tmrwd_pkg::ADDR_TIMER |=> o_rdata == $past(i_wdata, 2))
        else $error("timer load wrong");
    AST_WRST_HOLD: assert property ($rose(o_watchdog_reset_out) |-> o_watchdog_reset_out [*2])
        else $error("watchdog reset too short");
    AST_WRST_DROP: assert property (o_watchdog_reset_out [*2] |=> !o_watchdog_reset_out)
        else $error("watchdog reset too long");
    AST_WRST_NEEDS_EN: assert property (off_cnt == 4'h8 |-> !$rose(o_watchdog_reset_out))
        else $error("watchdog reset while disabled");
    AST_WRST_CLEAR: assert property ((i_core_reset || i_watchdog_clear_instr) [*2] |=>
        !$rose(o_watchdog_reset_out)) else $error("watchdog reset despite clear");
    cover property (i_wr && i_addr == tmrwd_pkg::ADDR_TIMER ##1 i_rd);
    cover property ($rose(o_irq));
    cover property (i_watchdog_clear_instr [*2]);
endmodule
`default_nettype wire

// *** tmrwd_count_source.sv ***
// Purpose: External event source driving the count pin.
// Assumes: Started by a one-cycle request with a pulse count.
// Notes: Edges land off the clock edge, like a source from another domain.
`timescale 1ns/100ps
`default_nettype none
module tmrwd_count_source (
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic [7:0] i_pulses,
    output logic o_pin,
    output logic o_busy
);
    int left;
    initial begin
        o_pin = 1'b0;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_start) begin
                left = i_pulses;
                #3 o_busy = 1'b1;
                // Four cycles each way leave margin over the capture chain.
                while (left > 0) begin
                    o_pin = 1'b1;
                    repeat (4) @(posedge i_clk);
                    #3 o_pin = 1'b0;
                    repeat (4) @(posedge i_clk);
                    #3 left--;
                end
                o_busy = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for the timer and watchdog block.
// Assumes: Register port with reads answered one cycle later.
// Notes: Free-running counts are checked as exact differences over whole periods.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clk, i_sys_rst, i_core_reset, i_watchdog_clear_instr, i_test, i_wr, i_rd;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, q, npulse;
    logic o_watchdog_reset_out, o_irq, pin, busy, start;
    int fail_count, n_tests;
    tmrwd_timer_subsystem u_tmrwd_timer_subsystem (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_core_reset(i_core_reset), .i_watchdog_clear_instr(i_watchdog_clear_instr),
        .i_external_count_input(pin), .i_test(i_test), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_watchdog_reset_out(o_watchdog_reset_out), .o_irq(o_irq));
    tmrwd_count_source u_tmrwd_count_source (.i_clk(i_clk), .i_start(start),
        .i_pulses(npulse), .o_pin(pin), .o_busy(busy));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic end_of_test;
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Write then read back at once, so nothing can move the value in between.
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, output logic [7:0] r);
        wr(a, d);
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 r = o_rdata;
    endtask
    // Two reads k+2 cycles apart must differ by exactly e.
    task automatic span(input logic [2:0] a, input int k, input logic [7:0] e, input string nm);
        logic [7:0] q0;
        logic [7:0] q1;
        rd(a, q0);
        repeat (k) @(posedge i_clk);
        rd(a, q1);
        chk(nm, q0 + e, q1);
    endtask
    initial begin
        {i_sys_rst, i_core_reset, i_watchdog_clear_instr, i_test, i_wr, i_rd} = 6'h20;
        {i_addr, i_wdata, npulse, start} = '0;
        fail_count = 0;
        n_tests = 0;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(tmrwd_pkg::ADDR_OPTION, q); chk("option", 8'h3F, q);
        rd(tmrwd_pkg::ADDR_STATUS, q); chk("status", 8'h00, q);
        rd(tmrwd_pkg::ADDR_MASK, q); chk("mask", 8'h00, q);
        wr(3'h6, 8'hAA); rd(3'h6, q); chk("unmapped", 8'h00, q);
        wr(tmrwd_pkg::ADDR_WDOG_LO, 8'hAA);
        rd(tmrwd_pkg::ADDR_WDOG_LO, q); chk("wdog_off", 8'h00, q);
        wr_rd(tmrwd_pkg::ADDR_TIMER, 8'hFF, q); chk("timer_load", 8'hFF, q);
        wr_rd(tmrwd_pkg::ADDR_OPTION, 8'h08, q); chk("option", 8'h08, q);
        repeat (12) @(posedge i_clk);
        rd(tmrwd_pkg::ADDR_STATUS, q); chk("ovf", 8'h01, q);
        chk("irq_masked", 8'h00, {7'h00, o_irq});
        wr(tmrwd_pkg::ADDR_MASK, 8'h01); repeat (2) @(posedge i_clk); #1;
        chk("irq_set", 8'h01, {7'h00, o_irq});
        wr(tmrwd_pkg::ADDR_STATUS, 8'h01); repeat (2) @(posedge i_clk); #1;
        chk("irq_clear", 8'h00, {7'h00, o_irq});
        span(tmrwd_pkg::ADDR_TIMER, 38, 8'h0A, "timer_undiv");
        for (int r = 0; r < 3; r++) begin
            wr(tmrwd_pkg::ADDR_OPTION, 8'(r));
            span(tmrwd_pkg::ADDR_TIMER, (40 << (r + 1)) - 2, 8'h0A, "timer_div");
        end
        wr(tmrwd_pkg::ADDR_OPTION, 8'h48);
        span(tmrwd_pkg::ADDR_WDOG_LO, 158, 8'h0A, "wdog_rate");
        rd(tmrwd_pkg::ADDR_WDOG_HI, q); chk("wdog_hi", 8'h00, q);
        @(posedge i_clk) i_watchdog_clear_instr <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_watchdog_clear_instr <= 1'b0;
        rd(tmrwd_pkg::ADDR_WDOG_LO, q); chk("wdog_clr", 8'h00, q & 8'hFE);
        @(posedge i_clk) i_core_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_core_reset <= 1'b0;
        rd(tmrwd_pkg::ADDR_WDOG_LO, q); chk("wdog_core", 8'h00, q & 8'hFE);
        rd(tmrwd_pkg::ADDR_OPTION, q); chk("option_core", 8'h7F, q);
        wr(tmrwd_pkg::ADDR_OPTION, 8'h28);
        @(posedge i_clk) i_test <= 1'b1;
        @(posedge i_clk) i_test <= 1'b0;
        wr_rd(tmrwd_pkg::ADDR_TIMER, 8'h00, q); chk("timer_load", 8'h00, q);
        @(posedge i_clk) {start, npulse} <= {1'b1, 8'h05};
        @(posedge i_clk) start <= 1'b0;
        repeat (2) @(posedge i_clk);
        for (int k = 0; k < 100 && busy !== 1'b0; k++) @(posedge i_clk);
        chk("source_done", 8'h00, {7'h00, busy});
        repeat (8) @(posedge i_clk);
        rd(tmrwd_pkg::ADDR_TIMER, q); chk("ext_count", 8'h05, q);
        wr_rd(tmrwd_pkg::ADDR_TIMER, 8'h5A, q); chk("timer_load", 8'h5A, q);
        @(posedge i_clk) i_sys_rst <= 1'b1;
        @(posedge i_clk) i_sys_rst <= 1'b0;
        rd(tmrwd_pkg::ADDR_TIMER, q); chk("timer_keep", 8'h5A, q);
        chk("wrst_idle", 8'h00, {7'h00, o_watchdog_reset_out});
        rd(tmrwd_pkg::ADDR_OPTION, q); chk("option", 8'h3F, q);
        end_of_test();
    end
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
endmodule
bind tmrwd_timer_subsystem tmrwd_timer_subsystem_sva u_tmrwd_timer_subsystem_sva (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_core_reset(i_core_reset),
    .i_watchdog_clear_instr(i_watchdog_clear_instr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_watchdog_reset_out(o_watchdog_reset_out), .o_irq(o_irq));
`default_nettype wire
